// ==== bench/esq_bus_partner.sv ====
/*
 * Bus partner: vector table memory, interrupting peripheral, request log.
 * Assumes one outstanding request and a done pulse of one cycle.
 */
`timescale 1ns/1ps
module esq_bus_partner (
    input wire logic sys_clk_i,
    input wire esq_pkg::esq_bus_req_t bus_i,
    input wire logic [7:0] ack_vec_i,
    input wire logic [3:0] lat_i,
    output logic bus_done_o,
    output logic [31:0] bus_rdata_o
);
    esq_pkg::esq_bus_req_t log_q[$];
    esq_pkg::esq_bus_req_t req;
    initial
    begin
        bus_done_o = 1'b0;
        bus_rdata_o = 32'h5a5a_a5a5;
        forever
        begin
            @(posedge sys_clk_i);
            #1;
            // Idle data keeps changing so stale values never match
            bus_rdata_o = ~bus_rdata_o;
            if (bus_i.valid === 1'b1)
            begin
                req = bus_i;
                // Logged when taken, so the log is complete at done
                log_q.push_back(req);
                repeat (lat_i) @(posedge sys_clk_i);
                #1;
                bus_done_o = 1'b1;
                case (req.space)
                    esq_pkg::ESQ_SP_INTERRUPT_ACK_CYCLE:
                        bus_rdata_o = {24'ha5a5a5, ack_vec_i};
                    esq_pkg::ESQ_SP_FETCH: bus_rdata_o = 32'h4e71_4e71;
                    default: bus_rdata_o = req.addr + 32'h1000;
                endcase
                @(posedge sys_clk_i);
                #1;
                bus_done_o = 1'b0;
            end
        end
    end
endmodule

// ==== bench/esq_exception_sequencer_tb.sv ====
/*
 * Self-checking bench of the exception sequencer.
 * Assumes the bus partner model and a 40 MHz clock.
 */
`timescale 1ns/1ps
module esq_exception_sequencer_tb;
    logic clk, rst, done, busy, flush;
    logic [31:0] rdata, fpc, npc, vbr, sp, pc, sp_m;
    logic [15:0] sr;
    logic [3:0] pst, lat;
    logic [7:0] ack_vec;
    esq_pkg::esq_exc_req_t exc;
    esq_pkg::esq_core_evt_t evt;
    esq_pkg::esq_bus_req_t bus;
    int num_errors, cmp_count;
    esq_exception_sequencer DUT (.sys_clk_i(clk), .rst_i(rst), .exc_i(exc),
        .evt_i(evt), .fault_pc_i(fpc), .next_pc_i(npc), .vbr_i(vbr),
        .bus_done_i(done), .bus_rdata_i(rdata), .bus_o(bus),
        .status_word_o(sr), .shared_stack_pointer_o(sp), .pc_o(pc),
        .busy_o(busy), .flush_o(flush), .processor_status_code_o(pst));
    esq_bus_partner u_partner (.sys_clk_i(clk), .bus_i(bus),
        .ack_vec_i(ack_vec), .lat_i(lat), .bus_done_o(done),
        .bus_rdata_o(rdata));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic ev(input esq_pkg::esq_core_evt_t e, input logic [3:0] code,
        input logic fl);
        evt = e;
        @(posedge clk);
        #1;
        evt = '0;
        check("pst", 32'(pst), 32'(code));
        check("flush", 32'(flush), 32'(fl));
        @(posedge clk);
        #1;
        check("idle pst", 32'(pst), 32'(esq_pkg::PST_CONT));
    endtask
    task automatic chk_req(input int i, input logic w, input logic [1:0] s,
        input logic [31:0] a);
        check("write", 32'(u_partner.log_q[i].write), 32'(w));
        check("space", 32'(u_partner.log_q[i].space), 32'(s));
        check("addr", u_partner.log_q[i].addr, a);
    endtask
    task automatic run_exc(input logic irq, input logic emu, input logic nx,
        input logic [2:0] lv, input logic [7:0] vec, input logic [15:0] osr,
        input logic [15:0] nsr, input logic [3:0] l);
        logic [31:0] base, pcv, va;
        int n, k;
        lat = l;
        base = (sp_m & esq_pkg::SP_ALIGN) - esq_pkg::FRAME_BYTES;
        pcv = nx ? npc : fpc;
        va = (vbr & esq_pkg::VBR_MASK) | {22'h0, irq ? ack_vec : vec, 2'b00};
        u_partner.log_q.delete();
        exc = '{start:1'b1, is_irq:irq, emu:emu, use_next:nx, level:lv,
            vector:vec};
        @(posedge clk);
        #1;
        exc.start = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 200)
        begin
            check("exc pst", 32'(pst),
                32'(emu ? esq_pkg::PST_EMU : esq_pkg::PST_EXC));
            // A start while busy must be ignored
            exc.start = (n == 2);
            exc.vector = 8'h99;
            @(posedge clk);
            #1;
            n++;
        end
        exc.start = 1'b0;
        check("exc end", 32'(busy), 32'h0);
        k = irq ? 1 : 0;
        check("reqs", u_partner.log_q.size(), 32'(k + 4));
        if (irq)
            chk_req(0, 1'b0, esq_pkg::ESQ_SP_INTERRUPT_ACK_CYCLE,
                esq_pkg::INTERRUPT_ACK_CYCLE_BASE | {27'h0, lv, 2'b00});
        chk_req(k, 1'b1, esq_pkg::ESQ_SP_DATA, base);
        check("frame sr", 32'(u_partner.log_q[k].wdata[15:0]),
            32'(osr));
        chk_req(k + 1, 1'b1, esq_pkg::ESQ_SP_DATA, base + 32'h4);
        check("frame pc", u_partner.log_q[k + 1].wdata, pcv);
        chk_req(k + 2, 1'b0, esq_pkg::ESQ_SP_DATA, va);
        chk_req(k + 3, 1'b0, esq_pkg::ESQ_SP_FETCH, va + 32'h1000);
        check("sr", 32'(sr), 32'(nsr));
        check("sp", sp, base);
        check("pc", pc, va + 32'h1000);
        sp_m = base;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #(2000 * 25);
        num_errors++;
        wrap_up();
    end
    initial
    begin
        rst = 1'b1;
        exc = '0;
        evt = '0;
        fpc = 32'h0000_1234;
        npc = 32'h0000_1236;
        vbr = 32'h0123_4567;
        ack_vec = 8'hff;
        lat = 4'h0;
        sp_m = 32'h0;
        num_errors = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        check("rst sr", 32'(sr), 32'(esq_pkg::SR_RESET));
        check("rst sp", sp, esq_pkg::SP_RESET);
        check("rst busy", {bus.valid, busy, flush, pst}, 32'h0);
        ev('{sr_write:1'b1, new_sr:16'h9000, default:'0},
            esq_pkg::PST_USER, 1'b1);
        check("sr wr", 32'(sr), 32'h9000);
        ev('{insn_begin:1'b1, default:'0}, esq_pkg::PST_BEGIN, 1'b0);
        ev('{pulse:1'b1, default:'0}, esq_pkg::PST_PULSE, 1'b0);
        ev('{branch:1'b1, default:'0}, esq_pkg::PST_BRANCH, 1'b0);
        run_exc(0, 0, 0, 3'h0, 8'h08, 16'h9000, 16'h3000, 4'h0);
        run_exc(1, 0, 1, 3'h5, 8'h08, 16'h3000, 16'h2500, 4'h3);
        run_exc(0, 1, 1, 3'h0, 8'h3f, 16'h2500, 16'h2500, 4'h1);
        ev('{ret:1'b1, new_sr:16'h0000, default:'0},
            esq_pkg::PST_RETURN, 1'b1);
        ev('{stopped:1'b1, default:'0}, esq_pkg::PST_STOP, 1'b0);
        ev('{halted:1'b1, default:'0}, esq_pkg::PST_HALT, 1'b0);
        wrap_up();
    end
endmodule

// ==== rtl/esq_exception_sequencer.sv ====
/*
 * Exception sequencer with processor status output.
 * Assumes a one-outstanding bus with a done pulse and read data, and
 * core events that are one-cycle pulses sampled on sys_clk_i.
 */
`timescale 1ns/1ps
module esq_exception_sequencer (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire esq_pkg::esq_exc_req_t exc_i,
    input wire esq_pkg::esq_core_evt_t evt_i,
    input wire logic [31:0] fault_pc_i,
    input wire logic [31:0] next_pc_i,
    input wire logic [31:0] vbr_i,
    input wire logic bus_done_i,
    input wire logic [31:0] bus_rdata_i,
    output esq_pkg::esq_bus_req_t bus_o,
    output logic [15:0] status_word_o,
    output logic [31:0] shared_stack_pointer_o,
    output logic [31:0] pc_o,
    output logic busy_o,
    output logic flush_o,
    output logic [3:0] processor_status_code_o
);
    typedef enum logic [2:0] {
        ESQ_IDLE = 3'b000,
        ESQ_INTERRUPT_ACK_CYCLE = 3'b001,
        ESQ_PUSH_SR = 3'b010,
        ESQ_PUSH_PC = 3'b011,
        ESQ_VEC = 3'b100,
        ESQ_FETCH = 3'b101
    } esq_state_t;

    esq_state_t state_reg;
    logic [15:0] sr_reg;
    logic [15:0] sr_copy_reg;
    logic [31:0] sp_reg;
    logic [31:0] pc_reg;
    logic [31:0] saved_pc_reg;
    logic [7:0] vec_reg;
    logic emu_reg;
    logic busy_reg;
    logic [3:0] pst_reg;
    logic [3:0] pst_next;
    logic [31:0] frame_base;

    assign frame_base = (sp_reg & esq_pkg::SP_ALIGN) - esq_pkg::FRAME_BYTES;

    function automatic logic [31:0] vec_addr(input logic [31:0] vbr,
                                             input logic [7:0] vec);
        vec_addr = (vbr & esq_pkg::VBR_MASK)
            | {22'h0, vec, 2'b00};
    endfunction

    // Sequencer
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ESQ_IDLE;
            vec_reg <= 8'h00;
            emu_reg <= 1'b0;
            busy_reg <= 1'b0;
            saved_pc_reg <= 32'h0000_0000;
            sr_copy_reg <= esq_pkg::SR_RESET;
        end
        else
        begin
            case (state_reg)
                ESQ_IDLE:
                    if (exc_i.start)
                    begin
                        sr_copy_reg <= sr_reg;
                        busy_reg <= 1'b1;
                        emu_reg <= exc_i.emu;
                        saved_pc_reg <= exc_i.use_next ? next_pc_i
                                                       : fault_pc_i;
                        vec_reg <= exc_i.vector;
                        state_reg <= exc_i.is_irq ? ESQ_INTERRUPT_ACK_CYCLE : ESQ_PUSH_SR;
                    end
                ESQ_INTERRUPT_ACK_CYCLE:
                    if (bus_done_i)
                    begin
                        vec_reg <= bus_rdata_i[7:0];
                        state_reg <= ESQ_PUSH_SR;
                    end
                ESQ_PUSH_SR:
                    if (bus_done_i)
                        state_reg <= ESQ_PUSH_PC;
                ESQ_PUSH_PC:
                    if (bus_done_i)
                        state_reg <= ESQ_VEC;
                ESQ_VEC:
                    if (bus_done_i)
                        state_reg <= ESQ_FETCH;
                ESQ_FETCH:
                    if (bus_done_i)
                    begin
                        state_reg <= ESQ_IDLE;
                        busy_reg <= 1'b0;
                    end
                default:
                begin
                    state_reg <= ESQ_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Status word
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            sr_reg <= esq_pkg::SR_RESET;
        else if (state_reg == ESQ_IDLE && exc_i.start)
        begin
            sr_reg[esq_pkg::SR_S] <= 1'b1;
            sr_reg[esq_pkg::SR_T] <= 1'b0;
            if (exc_i.is_irq)
            begin
                sr_reg[esq_pkg::SR_M] <= 1'b0;
                sr_reg[esq_pkg::SR_IPL_LO +: 3] <= exc_i.level;
            end
        end
        else if (state_reg == ESQ_IDLE && (evt_i.sr_write || evt_i.ret))
            sr_reg <= evt_i.new_sr;
    end

    // Shared stack pointer and program counter
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sp_reg <= esq_pkg::SP_RESET;
            pc_reg <= 32'h0000_0000;
        end
        else if (state_reg == ESQ_PUSH_PC && bus_done_i)
            sp_reg <= frame_base;
        else if (state_reg == ESQ_VEC && bus_done_i)
            pc_reg <= bus_rdata_i;
    end

    // Bus requests
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            bus_o <= '0;
        else
        begin
            bus_o <= '0;
            case (state_reg)
                ESQ_INTERRUPT_ACK_CYCLE:
                begin
                    bus_o.valid <= ~bus_done_i;
                    bus_o.space <= esq_pkg::ESQ_SP_INTERRUPT_ACK_CYCLE;
                    bus_o.addr <= esq_pkg::INTERRUPT_ACK_CYCLE_BASE
                        | {27'h0, sr_reg[esq_pkg::SR_IPL_LO +: 3], 2'b00};
                end
                ESQ_PUSH_SR:
                begin
                    bus_o.valid <= ~bus_done_i;
                    bus_o.write <= 1'b1;
                    bus_o.addr <= frame_base;
                    bus_o.wdata <= {16'h0000, sr_copy_reg};
                end
                ESQ_PUSH_PC:
                begin
                    bus_o.valid <= ~bus_done_i;
                    bus_o.write <= 1'b1;
                    bus_o.addr <= frame_base + 32'h0000_0004;
                    bus_o.wdata <= saved_pc_reg;
                end
                ESQ_VEC:
                begin
                    bus_o.valid <= ~bus_done_i;
                    bus_o.addr <= vec_addr(vbr_i, vec_reg);
                end
                ESQ_FETCH:
                begin
                    bus_o.valid <= ~bus_done_i;
                    bus_o.space <= esq_pkg::ESQ_SP_FETCH;
                    bus_o.addr <= pc_reg;
                end
                default:
                    bus_o <= '0;
            endcase
        end
    end

    // Pipeline flush on supervisor change
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            flush_o <= 1'b0;
        else
            flush_o <= state_reg == ESQ_IDLE && !exc_i.start
                && (evt_i.sr_write || evt_i.ret)
                && evt_i.new_sr[esq_pkg::SR_S]
                != sr_reg[esq_pkg::SR_S];
    end

    // Processor status encoding
    always_comb
    begin
        pst_next = esq_pkg::PST_CONT;
        if (state_reg != ESQ_IDLE || exc_i.start)
            pst_next = (state_reg == ESQ_IDLE ? exc_i.emu : emu_reg)
                ? esq_pkg::PST_EMU : esq_pkg::PST_EXC;
        else if (evt_i.halted)
            pst_next = esq_pkg::PST_HALT;
        else if (evt_i.stopped)
            pst_next = esq_pkg::PST_STOP;
        else if (evt_i.ret)
            pst_next = esq_pkg::PST_RETURN;
        else if (evt_i.sr_write && !evt_i.new_sr[esq_pkg::SR_S]
                 && sr_reg[esq_pkg::SR_S])
            pst_next = esq_pkg::PST_USER;
        else if (evt_i.pulse)
            pst_next = esq_pkg::PST_PULSE;
        else if (evt_i.branch)
            pst_next = esq_pkg::PST_BRANCH;
        else if (evt_i.insn_begin)
            pst_next = esq_pkg::PST_BEGIN;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            pst_reg <= esq_pkg::PST_CONT;
        else
            pst_reg <= pst_next;
    end

    assign processor_status_code_o = pst_reg;
    assign status_word_o = sr_reg;
    assign shared_stack_pointer_o = sp_reg;
    assign pc_o = pc_reg;
    assign busy_o = busy_reg;

    reserved_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !(pst_reg inside {4'h2, 4'h6, [4'h8:4'hb]}))
        else $error("reserved status code driven");
    exc_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg != ESQ_IDLE) |=> pst_reg inside {4'hc, 4'hd})
        else $error("exception code not held");
    enter_sup_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == ESQ_IDLE && exc_i.start) |=>
        sr_reg[13] && !sr_reg[15] && sr_copy_reg == $past(sr_reg))
        else $error("supervisor entry wrong");
    irq_mask_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == ESQ_IDLE && exc_i.start && exc_i.is_irq) |=>
        !sr_reg[12] && sr_reg[10:8] == $past(exc_i.level))
        else $error("interrupt mask not loaded");
    interrupt_ack_cycle_space_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (bus_o.valid && bus_o.space == esq_pkg::ESQ_SP_INTERRUPT_ACK_CYCLE) |->
        bus_o.addr[4:2] == sr_reg[10:8])
        else $error("acknowledge level missing");
    frame_align_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (bus_o.valid && bus_o.write) |-> bus_o.addr[1:0] == 2'b00)
        else $error("frame misaligned");
    vec_fetch_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (bus_o.valid && state_reg == ESQ_VEC) |->
        bus_o.addr[19:0] == {10'h0, vec_reg, 2'b00})
        else $error("vector address wrong");
    sequence handler_fetch_s;
        state_reg == ESQ_FETCH && bus_done_i;
    endsequence
    handler_end_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        handler_fetch_s |=> state_reg == ESQ_IDLE)
        else $error("exception did not end");
    flush_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (state_reg == ESQ_IDLE && !exc_i.start && evt_i.sr_write
         && evt_i.new_sr[13] != sr_reg[13]) |=> flush_o)
        else $error("no flush on mode change");
endmodule

// ==== shared/esq_pkg.sv ====
/*
 * Constants and carriers of the exception sequencer.
 * Assumes a 32-bit core with a 16-bit status word.
 */
package esq_pkg;
    localparam logic [3:0] PST_CONT = 4'h0;
    localparam logic [3:0] PST_BEGIN = 4'h1;
    localparam logic [3:0] PST_USER = 4'h3;
    localparam logic [3:0] PST_PULSE = 4'h4;
    localparam logic [3:0] PST_BRANCH = 4'h5;
    localparam logic [3:0] PST_RETURN = 4'h7;
    localparam logic [3:0] PST_EXC = 4'hc;
    localparam logic [3:0] PST_EMU = 4'hd;
    localparam logic [3:0] PST_STOP = 4'he;
    localparam logic [3:0] PST_HALT = 4'hf;
    // Status word fields
    localparam int SR_T = 15;
    localparam int SR_S = 13;
    localparam int SR_M = 12;
    localparam int SR_IPL_LO = 8;
    localparam logic [15:0] SR_RESET = 16'h2700;
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    localparam logic [31:0] VBR_MASK = 32'hfff0_0000;
    localparam logic [31:0] SP_ALIGN = 32'hffff_fffc;
    localparam logic [31:0] FRAME_BYTES = 32'h0000_0008;
    localparam logic [7:0] USER_VEC_FIRST = 8'h40;
    localparam logic [31:0] INTERRUPT_ACK_CYCLE_BASE = 32'hffff_ffe0;
    // Bus cycle kinds
    typedef enum logic [1:0] {
        ESQ_SP_DATA = 2'b00,
        ESQ_SP_INTERRUPT_ACK_CYCLE = 2'b01,
        ESQ_SP_FETCH = 2'b10
    } esq_space_t;
    typedef struct packed {
        logic valid;
        logic write;
        esq_space_t space;
        logic [31:0] addr;
        logic [31:0] wdata;
    } esq_bus_req_t;
    typedef struct packed {
        logic start;
        logic is_irq;
        logic emu;
        logic use_next;
        logic [2:0] level;
        logic [7:0] vector;
    } esq_exc_req_t;
    typedef struct packed {
        logic insn_begin;
        logic pulse;
        logic branch;
        logic ret;
        logic sr_write;
        logic stopped;
        logic halted;
        logic [15:0] new_sr;
    } esq_core_evt_t;
endpackage
